// ---- design/pmcc_consts.svh ----
// constants for the push-motion current control block
`ifndef PMCC_CONSTS_SVH
`define PMCC_CONSTS_SVH
`define PMCC_CUR_W          10
`define PMCC_CUR_MAX        10'h3e8
`define PMCC_CUR_RST        10'h3e8
`define PMCC_CUTBACK_EN_RST 1'b1
`define PMCC_DELAY_W        10
`define PMCC_DELAY_MAX_MS   10'h3e8
`define PMCC_DELAY_RST_MS   10'h064
`define PMCC_STANDSTILL_RST 1'b0
`define PMCC_CLK_MHZ        125
`define PMCC_MS_NS          1000000
`define PMCC_CLK_NS         8
`define PMCC_MS_CYCLES      (`PMCC_MS_NS / `PMCC_CLK_NS)
`define PMCC_MAX_SEL_PINS   5
`define PMCC_POS_W          32
`endif

// ---- design/pmcc_pkg.sv ----
// types for the push-motion current control block
`default_nettype none
package pmcc_pkg;
    typedef enum logic [2:0] {
        PMCC_RUN  = 3'b001,
        PMCC_WAIT = 3'b010,
        PMCC_CUT  = 3'b100
    } pmcc_cur_state_t;
endpackage
`default_nettype wire

// ---- design/pmcc_push_ctrl.sv ----
// push-motion current control: current choice, cutback, torque flag, deviation
`default_nettype none
`include "pmcc_consts.svh"
module pmcc_push_ctrl #(
    parameter int SEL_W     = 8,
    parameter int ENTRIES   = 256,
    parameter int MS_CYCLES = `PMCC_MS_CYCLES
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     ce_i,
    input  wire logic                     push_mode_i,
    input  wire logic                     step_i,
    input  wire logic                     dir_i,
    input  wire logic                     shaft_step_i,
    input  wire logic [SEL_W-1:0]         data_number_select_i,
    input  wire logic [SEL_W-1:0]         sel_assign_mask_i,
    input  wire logic                     cur_wr_i,
    input  wire logic [7:0]               cur_wr_idx_i,
    input  wire logic [`PMCC_CUR_W-1:0]   cur_wr_val_i,
    input  wire logic                     cutback_en_wr_i,
    input  wire logic                     cutback_en_i,
    input  wire logic                     delay_wr_i,
    input  wire logic [`PMCC_DELAY_W-1:0] delay_ms_i,
    input  wire logic                     standstill_wr_i,
    input  wire logic                     standstill_op_i,
    input  wire logic [`PMCC_CUR_W-1:0]   stop_cur_i,
    input  wire logic [`PMCC_CUR_W-1:0]   torque_i,
    input  wire logic                     overload_i,
    input  wire logic [`PMCC_POS_W-1:0]   dev_limit_i,
    output logic      [`PMCC_CUR_W-1:0]   cur_cmd_o,
    output logic      [`PMCC_CUR_W-1:0]   torque_limit_o,
    output logic                          torque_limit_reached_o,
    output logic                          overload_alarm_o,
    output logic                          deviation_alarm_o,
    output logic      [`PMCC_POS_W-1:0]   deviation_o,
    output logic                          catch_up_o,
    output logic                          sel_assign_err_o
);
    logic [`PMCC_CUR_W-1:0]   cur_tab_ff [ENTRIES];
    logic                     cutback_en_ff;
    logic [`PMCC_DELAY_W-1:0] delay_ms_ff;
    logic                     standstill_op_ff;
    logic [SEL_W-1:0]         sel_eff;
    logic                     sel_err;
    logic [7:0]               data_no;
    logic [`PMCC_CUR_W-1:0]   op_cur;
    pmcc_pkg::pmcc_cur_state_t state_ff;
    pmcc_pkg::pmcc_cur_state_t nxt_state;
    logic [31:0]              tick_ff;
    logic [`PMCC_DELAY_W-1:0] ms_ff;
    logic [`PMCC_POS_W-1:0]   dev_ff;
    logic                     push_ff;
    logic [`PMCC_CUR_W-1:0]   nxt_cur;
    logic                     delay_done;

    pmcc_sel_decode #(.SEL_W(SEL_W)) u_sel (
        .sel_i        (data_number_select_i),
        .assign_mask_i(sel_assign_mask_i),
        .sel_eff_o    (sel_eff),
        .assign_err_o (sel_err)
    );

    assign data_no = 8'(sel_eff);
    assign op_cur  = cur_tab_ff[data_no];

    // operation data table, writes above the range are clamped
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_tab
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    cur_tab_ff[g] <= `PMCC_CUR_RST;
                end else if (ce_i && cur_wr_i && (cur_wr_idx_i == 8'(g))) begin
                    cur_tab_ff[g] <= (cur_wr_val_i > `PMCC_CUR_MAX) ?
                                     `PMCC_CUR_MAX : cur_wr_val_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cutback_en_ff    <= `PMCC_CUTBACK_EN_RST;
            delay_ms_ff      <= `PMCC_DELAY_RST_MS;
            standstill_op_ff <= `PMCC_STANDSTILL_RST;
        end else if (ce_i) begin
            if (cutback_en_wr_i) begin
                cutback_en_ff <= cutback_en_i;
            end
            if (delay_wr_i) begin
                delay_ms_ff <= (delay_ms_i > `PMCC_DELAY_MAX_MS) ?
                               `PMCC_DELAY_MAX_MS : delay_ms_i;
            end
            if (standstill_wr_i) begin
                standstill_op_ff <= standstill_op_i;
            end
        end
    end

    AST_DELAY_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        delay_ms_ff <= `PMCC_DELAY_MAX_MS)
        else $error("cutback delay above range");
    AST_CB_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !(ce_i && cutback_en_wr_i) |=> cutback_en_ff == $past(cutback_en_ff))
        else $error("cutback setting changed without a write");

    // millisecond timer since last step pulse
    assign delay_done = (ms_ff >= delay_ms_ff);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tick_ff <= 32'h0;
            ms_ff   <= '0;
        end else if (ce_i) begin
            if (step_i) begin
                tick_ff <= 32'h0;
                ms_ff   <= '0;
            end else if (!delay_done) begin
                if (tick_ff == 32'(MS_CYCLES - 1)) begin
                    tick_ff <= 32'h0;
                    ms_ff   <= ms_ff + 10'h001;
                end else begin
                    tick_ff <= tick_ff + 32'h1;
                end
            end
        end
    end

    always_comb begin
        case (state_ff)
            pmcc_pkg::PMCC_RUN:  nxt_state = step_i ? pmcc_pkg::PMCC_RUN : pmcc_pkg::PMCC_WAIT;
            pmcc_pkg::PMCC_WAIT: begin
                if (step_i) begin
                    nxt_state = pmcc_pkg::PMCC_RUN;
                end else if (delay_done) begin
                    nxt_state = pmcc_pkg::PMCC_CUT;
                end else begin
                    nxt_state = pmcc_pkg::PMCC_WAIT;
                end
            end
            pmcc_pkg::PMCC_CUT:  nxt_state = step_i ? pmcc_pkg::PMCC_RUN : pmcc_pkg::PMCC_CUT;
            default:             nxt_state = pmcc_pkg::PMCC_RUN;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_ff <= pmcc_pkg::PMCC_RUN;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    AST_STATE_ONEHOT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $onehot(state_ff))
        else $error("current state not one-hot");
    AST_WAIT_NO_CUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && state_ff == pmcc_pkg::PMCC_WAIT && !step_i && !delay_done
            |=> state_ff == pmcc_pkg::PMCC_WAIT)
        else $error("left the wait state before the delay");

    // current choice: stop current only after delay, when cutback is allowed
    always_comb begin
        nxt_cur = op_cur;
        if (state_ff == pmcc_pkg::PMCC_CUT && cutback_en_ff) begin
            if (!(push_mode_i && standstill_op_ff)) begin
                nxt_cur = stop_cur_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur_cmd_o      <= `PMCC_CUR_RST;
            torque_limit_o <= `PMCC_CUR_RST;
            push_ff        <= 1'b0;
        end else if (ce_i) begin
            cur_cmd_o      <= nxt_cur;
            torque_limit_o <= op_cur;
            push_ff        <= push_mode_i;
        end
    end

    AST_CUR_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && state_ff == pmcc_pkg::PMCC_CUT && cutback_en_ff &&
        !(push_mode_i && standstill_op_ff) |=> cur_cmd_o == $past(stop_cur_i))
        else $error("stop current not applied after cutback");
    AST_CUR_PUSH_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && push_mode_i && standstill_op_ff |=> cur_cmd_o == $past(op_cur))
        else $error("push standstill current not the operating current");
    AST_CUR_RUN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && state_ff != pmcc_pkg::PMCC_CUT |=> cur_cmd_o == $past(op_cur))
        else $error("operating current not applied in motion");
    AST_FREEZE_CUR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(cur_cmd_o) && $stable(state_ff))
        else $error("current state moved while clock enable low");

    // commanded minus shaft position; pulses count even when shaft stalls
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dev_ff <= '0;
        end else if (ce_i) begin
            case ({step_i, shaft_step_i})
                2'b10:   dev_ff <= dir_i ? dev_ff - 32'h1 : dev_ff + 32'h1;
                2'b01:   dev_ff <= dir_i ? dev_ff + 32'h1 : dev_ff - 32'h1;
                default: dev_ff <= dev_ff;
            endcase
        end
    end

    AST_STEP_UP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && step_i && !shaft_step_i && !dir_i |=> dev_ff == $past(dev_ff) + 32'h1)
        else $error("forward step not accumulated");
    AST_STEP_DOWN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && step_i && !shaft_step_i && dir_i |=> dev_ff == $past(dev_ff) - 32'h1)
        else $error("reverse step not accumulated");
    AST_STEP_CANCEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && step_i && shaft_step_i |=> dev_ff == $past(dev_ff))
        else $error("step and shaft step did not cancel");
    AST_SHAFT_DOWN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && !step_i && shaft_step_i && !dir_i |=> dev_ff == $past(dev_ff) - 32'h1)
        else $error("forward shaft step not released");
    AST_SHAFT_UP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && !step_i && shaft_step_i && dir_i |=> dev_ff == $past(dev_ff) + 32'h1)
        else $error("reverse shaft step not released");
    AST_FREEZE_DEV: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(dev_ff) && $stable(deviation_o))
        else $error("deviation moved while clock enable low");

    logic [`PMCC_POS_W-1:0] dev_abs;
    assign dev_abs = dev_ff[`PMCC_POS_W-1] ? (~dev_ff + 32'h1) : dev_ff;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            torque_limit_reached_o <= 1'b0;
            overload_alarm_o       <= 1'b0;
            deviation_alarm_o      <= 1'b0;
            deviation_o            <= '0;
            catch_up_o             <= 1'b0;
            sel_assign_err_o       <= 1'b0;
        end else if (ce_i) begin
            torque_limit_reached_o <= push_mode_i && (torque_i >= op_cur);
            overload_alarm_o       <= overload_i && !push_mode_i;
            if (dev_abs > dev_limit_i) begin
                deviation_alarm_o <= 1'b1;
            end
            deviation_o            <= dev_ff;
            // load released: drive out the backlog at high speed
            catch_up_o             <= push_ff && (dev_ff != '0) && (torque_i < op_cur);
            sel_assign_err_o       <= sel_err;
        end
    end

    AST_OVL_SUPPRESS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && push_mode_i |=> !overload_alarm_o)
        else $error("overload alarm raised in push mode");
    AST_TLC_RISE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && push_mode_i && torque_i >= op_cur |=> torque_limit_reached_o)
        else $error("torque flag missing");
    AST_TLC_ONLY_PUSH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && !push_mode_i |=> !torque_limit_reached_o)
        else $error("torque flag outside push mode");
    AST_NO_EARLY_CUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_ff == pmcc_pkg::PMCC_CUT |-> delay_done)
        else $error("cutback before delay");
    AST_RESTORE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && step_i |=> state_ff == pmcc_pkg::PMCC_RUN && ms_ff == '0)
        else $error("step did not restore current");
    AST_NO_CUT_DIS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && !cutback_en_ff |=> cur_cmd_o == $past(op_cur))
        else $error("cutback while disabled");
    AST_TAB_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        op_cur <= `PMCC_CUR_MAX)
        else $error("current above range");
    AST_SEL_LIMIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $countones(sel_eff & ~data_number_select_i) == 0 && $countones(u_sel.keep) <= 5)
        else $error("too many select pins");
    AST_DEV_ALARM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && dev_abs > dev_limit_i |=> deviation_alarm_o)
        else $error("deviation alarm missing");
    AST_OVL_PASS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && overload_i && !push_mode_i |=> overload_alarm_o)
        else $error("overload alarm missing outside push mode");
    AST_OVL_QUIET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && !overload_i |=> !overload_alarm_o)
        else $error("overload alarm without overload");
    AST_TLC_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && torque_i < op_cur |=> !torque_limit_reached_o)
        else $error("torque flag below the limit");
    AST_TLIM_FOLLOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i |=> torque_limit_o == $past(op_cur))
        else $error("torque limit does not follow push current");
    AST_DEV_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        deviation_alarm_o |=> deviation_alarm_o)
        else $error("deviation alarm cleared without reset");
    AST_DEV_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i |=> deviation_o == $past(dev_ff))
        else $error("deviation output lags the count");
    AST_CATCH_UP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && push_ff && dev_ff != '0 && torque_i < op_cur |=> catch_up_o)
        else $error("catch-up missing after load release");
    AST_CATCH_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i && dev_ff == '0 |=> !catch_up_o)
        else $error("catch-up with no backlog");
    AST_SEL_ERR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_i |=> sel_assign_err_o == $past(sel_err))
        else $error("select assignment error not reported");
endmodule // pmcc_push_ctrl
`default_nettype wire

// ---- design/pmcc_sel_decode.sv ----
// data-number select decoder with a five-pin assignment limit
`default_nettype none
`include "pmcc_consts.svh"
module pmcc_sel_decode #(
    parameter int SEL_W = 8
) (
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic [SEL_W-1:0] assign_mask_i,
    output logic      [SEL_W-1:0] sel_eff_o,
    output logic                  assign_err_o
);
    logic [3:0] cnt;
    logic [SEL_W-1:0] keep;
    always_comb begin
        cnt  = 4'h0;
        keep = '0;
        for (int i = 0; i < SEL_W; i++) begin
            // only the first five mapped inputs are honoured
            if (assign_mask_i[i] && (cnt < 4'(`PMCC_MAX_SEL_PINS))) begin
                keep[i] = 1'b1;
                cnt     = cnt + 4'h1;
            end
        end
    end
    assign sel_eff_o    = sel_i & keep;
    assign assign_err_o = (assign_mask_i & ~keep) != '0;
endmodule // pmcc_sel_decode
`default_nettype wire

// ---- test/pmcc_master_model.sv ----
// master controller model: issues bursts of step pulses
`default_nettype none
module pmcc_master_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [7:0] count_i,
    input  wire logic       dir_cmd_i,
    output logic            step_o,
    output logic            dir_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_ff;
    // one step every other cycle, then silence until the next burst
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            left_ff <= 8'h00;
            step_o  <= 1'b0;
            dir_o   <= 1'b0;
        end else begin
            step_o <= 1'b0;
            if (left_ff == 8'h00 && go_i) begin
                left_ff <= count_i;
                dir_o   <= dir_cmd_i;
            end else if (left_ff != 8'h00 && !step_o) begin
                step_o  <= 1'b1;
                left_ff <= left_ff - 8'h01;
            end
        end
    end
    assign busy_o = (left_ff != 8'h00) || step_o;
endmodule // pmcc_master_model
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the push-motion current control block
`default_nettype none
`include "pmcc_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i, rst_n_i, push, step, dir, dir_c, shaft, go, busy, ovl;
    logic        cur_wr, cb_wr, cb_en, dl_wr, ss_wr, ss_op, ce;
    logic        tlr, ovl_alm, dev_alm, catch_up, sel_err;
    logic [7:0]  sel, mask, idx, cnt;
    logic [9:0]  val, dl, stop_cur, torque, cur_cmd, tlim;
    logic [31:0] dev_lim, dev;
    int          bad_count, total_checks, tbl[256], exp_dev, op, n, k, v, pm, ss, cb;

    pmcc_master_model pmcc_master_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go),
        .count_i(cnt), .dir_cmd_i(dir_c), .step_o(step), .dir_o(dir), .busy_o(busy));
    pmcc_push_ctrl #(.MS_CYCLES(10)) pmcc_push_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .push_mode_i(push), .step_i(step), .dir_i(dir), .shaft_step_i(shaft),
        .data_number_select_i(sel), .sel_assign_mask_i(mask), .cur_wr_i(cur_wr),
        .cur_wr_idx_i(idx), .cur_wr_val_i(val), .cutback_en_wr_i(cb_wr), .cutback_en_i(cb_en),
        .delay_wr_i(dl_wr), .delay_ms_i(dl), .standstill_wr_i(ss_wr), .standstill_op_i(ss_op),
        .stop_cur_i(stop_cur), .torque_i(torque), .overload_i(ovl), .dev_limit_i(dev_lim),
        .cur_cmd_o(cur_cmd), .torque_limit_o(tlim), .torque_limit_reached_o(tlr),
        .overload_alarm_o(ovl_alm), .deviation_alarm_o(dev_alm), .deviation_o(dev),
        .catch_up_o(catch_up), .sel_assign_err_o(sel_err));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task give_verdict;
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task wait_n(input int c);
        repeat (c) @(negedge mclk_i);
    endtask

    // kind 0 current table, 1 cutback enable, 2 delay, 3 standstill choice
    task cfg_wr(input int kind, input int x);
        @(posedge mclk_i);
        case (kind)
            0: begin cur_wr <= 1'b1; idx <= n[7:0]; val <= x[9:0]; end
            1: begin cb_wr <= 1'b1; cb_en <= x[0]; end
            2: begin dl_wr <= 1'b1; dl <= x[9:0]; end
            default: begin ss_wr <= 1'b1; ss_op <= x[0]; end
        endcase
        @(posedge mclk_i);
        {cur_wr, cb_wr, dl_wr, ss_wr} <= 4'h0;
        wait_n(3);
    endtask

    task run(input int c, input logic d);
        @(posedge mclk_i);
        go    <= 1'b1;
        cnt   <= c[7:0];
        dir_c <= d;
        @(posedge mclk_i);
        go <= 1'b0;
        exp_dev += d ? -c : c;
        k = 0;
        @(negedge mclk_i);
        while (busy === 1'b1 && k < 100) begin
            @(negedge mclk_i);
            k++;
        end
        if (k == 100) begin
            bad_count++;
            give_verdict;
        end
        wait_n(2);
    endtask

    initial begin
        void'($urandom(32'hae2c));
        {push, shaft, go, ovl, dir_c, cur_wr, cb_wr, cb_en, dl_wr, ss_wr, ss_op} = '0;
        {sel, idx, cnt, val, dl, stop_cur, torque} = '0;
        ce = 1'b1;
        mask = 8'h1f;
        dev_lim = 32'h7fffffff;
        rst_n_i = 1'b0;
        bad_count = 0;
        total_checks = 0;
        exp_dev = 0;
        foreach (tbl[i]) tbl[i] = 1000;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        wait_n(2);
        chk("cur_cmd", cur_cmd, 1000);
        chk("torque_limit", tlim, 1000);
        n = $urandom_range(31, 1);
        @(posedge mclk_i) sel <= n[7:0];
        for (int i = 0; i < 3; i++) begin
            v = (i == 1) ? 1023 : $urandom_range(1000, 1);
            cfg_wr(0, v);
            tbl[n] = (v > 1000) ? 1000 : v;
            chk("torque_limit", tlim, tbl[n]);
        end
        // unmapped select bits must not change the data number
        @(posedge mclk_i) sel <= 8'he0;
        wait_n(3);
        chk("torque_limit", tlim, tbl[0]);
        @(posedge mclk_i) begin sel <= n[7:0]; mask <= 8'h3f; end
        wait_n(3);
        chk("sel_err", sel_err, 1);
        @(posedge mclk_i) mask <= 8'h1f;
        wait_n(3);
        chk("sel_err", sel_err, 0);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_i) begin push <= i[0]; ovl <= 1'b1; end
            wait_n(3);
            chk("overload_alarm", ovl_alm, i == 0);
        end
        op = tbl[n];
        @(posedge mclk_i) begin push <= 1'b0; ovl <= 1'b0; stop_cur <= 10'(op - 1); end
        cfg_wr(2, 3);
        run(4, 0);
        chk("deviation", dev, exp_dev);
        chk("cur_cmd", cur_cmd, op);
        wait_n(40);
        chk("cur_cmd", cur_cmd, op - 1);
        for (int j = 0; j < 3; j++) begin
            pm = j < 2;
            ss = j == 0;
            cb = j != 2;
            cfg_wr(3, ss);
            cfg_wr(1, cb);
            @(posedge mclk_i) push <= pm[0];
            run(2, j[0]);
            chk("deviation", dev, exp_dev);
            wait_n(40);
            chk("cur_cmd", cur_cmd, (cb && !(pm && ss)) ? op - 1 : op);
            run(1, 0);
            chk("cur_cmd", cur_cmd, op);
            chk("catch_up", catch_up, pm);
            @(posedge mclk_i) torque <= op[9:0];
            wait_n(3);
            chk("torque_flag", tlr, pm);
            @(posedge mclk_i) torque <= 10'h000;
        end
        @(posedge mclk_i) shaft <= 1'b1;
        @(posedge mclk_i) shaft <= 1'b0;
        exp_dev--;
        wait_n(3);
        chk("deviation", dev, exp_dev);
        @(posedge mclk_i) dev_lim <= exp_dev;
        wait_n(3);
        chk("deviation_alarm", dev_alm, 0);
        run(1, 0);
        chk("deviation_alarm", dev_alm, 1);
        // clock enable low: a shaft step must not be counted
        @(posedge mclk_i) begin ce <= 1'b0; shaft <= 1'b1; end
        @(posedge mclk_i) shaft <= 1'b0;
        wait_n(3);
        chk("deviation", dev, exp_dev);
        @(posedge mclk_i) ce <= 1'b1;
        wait_n(3);
        chk("deviation", dev, exp_dev);
        give_verdict;
    end
endmodule // tb
`default_nettype wire
